// [stepper_ctrl.sv]
// Top level: bus slave, resets, interrupt, watchdog and step timing
`timescale 1ns/1ps
// Operation
// - Reset pin low holds everything at defaults
// - Acknowledge general call write, refuse read
// - Acknowledge only reset code after call
// - Refuse every byte after reset code
// - Reset code then stop resets device
// - Repeated start after code cancels reset
// - Watchdog expiry sets flag and interrupt
// - Pin interrupt needs input, mask, edge
// - Mode bit five disables interrupt pin
// - Pin interrupt sets its status flag
// - Interrupt pin open-drain, low when pending
// - Wave drive: one winding, D C B A
// - Two-phase: adjacent pairs D+C onward
// - Half-step: eight patterns from D
// - Start and stop seen while clock high
// - Data stable in clock high phase
// - Slave pulls data low on ninth pulse
// - Master refusal makes transmitter release line
// - Multi-byte writes advance pointer, byte reads
// - First start energizes reference coil uncounted
// - Later starts resume last stop pattern
module stepper_ctrl #(
  parameter int WD_UNIT_CYCLES = stepper_pkg::WD_UNIT_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic RESET_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic INT_N_OUT,
  output logic INT_N_OE,
  input wire logic [3:0] GPIO_IN,
  output logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_OE,
  output logic COIL_DRIVE_FIRST,
  output logic COIL_DRIVE_SECOND,
  output logic COIL_DRIVE_THIRD,
  output logic COIL_DRIVE_FOURTH
);
  stepper_pkg::pins_t s1_reg;
  stepper_pkg::pins_t s2_reg;
  stepper_pkg::pins_t s3_reg;
  stepper_pkg::pins_t pin_reg;
  stepper_pkg::pins_t pin_prev_reg;
  stepper_pkg::pins_t pin_next;
  stepper_pkg::bus_st_t st_reg;
  stepper_pkg::bus_st_t st_next;
  stepper_pkg::bus_st_t nxt_reg;
  stepper_pkg::bus_st_t nxt_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic ack_reg;
  logic ack_next;
  logic oe_reg;
  logic oe_next;
  logic gc_reg;
  logic gc_next;
  logic bus_reset_call_reg;
  logic [7:0] regs_reg [stepper_pkg::NREG];
  logic [3:0] int_flag_reg;
  logic wd_flag_reg;
  logic int_oe_reg;
  logic [13:0] wd_pre_reg;
  logic [7:0] wd_cnt_reg;
  logic run_q_reg;
  logic [6:0] step_pre_reg;
  logic [7:0] step_cnt_reg;
  logic [3:0] coil;
  stepper_pkg::motor_cmd_t cmd;

  // A pin change counts once the second and third stages agree
  wire stepper_pkg::pins_t pin_raw = {RESET_N, SCL_IN, SDA_IN, GPIO_IN};
  wire logic [6:0] agree = ~(s2_reg ^ s3_reg);
  assign pin_next = (agree & s3_reg) | (~agree & pin_reg);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_reg <= stepper_pkg::SYNC_INIT;
      s2_reg <= stepper_pkg::SYNC_INIT;
      s3_reg <= stepper_pkg::SYNC_INIT;
      pin_reg <= stepper_pkg::SYNC_INIT;
      pin_prev_reg <= stepper_pkg::SYNC_INIT;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
      pin_prev_reg <= pin_reg;
    end
  end

  // Bus events; a data change while the clock is high is control
  wire logic scl_hi = pin_reg.scl & pin_prev_reg.scl;
  wire logic scl_rise = pin_reg.scl & ~pin_prev_reg.scl;
  wire logic scl_fall = ~pin_reg.scl & pin_prev_reg.scl;
  wire logic start_det = scl_hi & pin_prev_reg.sda & ~pin_reg.sda;
  wire logic stop_det = scl_hi & ~pin_prev_reg.sda & pin_reg.sda;
  // Reset pin level and the software reset both clear all state but the pin synchronizers
  wire logic clr = ~pin_reg.rst_n | bus_reset_call_reg;

  // Byte decode at the end of the eighth bit
  wire logic rx_st = st_reg inside {stepper_pkg::ST_ADDR,
    stepper_pkg::ST_PTR, stepper_pkg::ST_WDATA,
    stepper_pkg::ST_GCODE, stepper_pkg::ST_GMORE};
  wire logic decide = scl_fall & rx_st & ~ack_reg & (cnt_reg == 4'h8);
  wire logic ack_end = scl_fall & ack_reg & (st_reg != stepper_pkg::ST_SKIP);
  wire logic own_hit = sh_reg[7:1] == stepper_pkg::DEV_ADDR;
  wire logic gc_wr = sh_reg == stepper_pkg::GCALL_WR;
  wire logic code_ok = sh_reg == stepper_pkg::RESET_CODE;
  wire logic load_tx = ack_end & (nxt_reg == stepper_pkg::ST_RDATA);
  wire logic mst_nack = scl_rise & ack_reg & pin_reg.sda &
                        (st_reg == stepper_pkg::ST_RDATA);

  // Register port: write on the data byte decision, read at load
  wire logic wr_en = decide & (st_reg == stepper_pkg::ST_WDATA);
  wire logic [3:0] wr_idx = ptr_reg;
  wire logic [7:0] wr_data = sh_reg;
  wire logic ptr_ok = ptr_reg < 4'(stepper_pkg::NREG);
  wire logic [7:0] reg_sel = ptr_ok ? regs_reg[ptr_reg] : 8'h00;
  wire logic [7:0] wd_view = {reg_sel[7:4], wd_flag_reg, reg_sel[2:0]};
  wire logic [7:0] rd_data =
    (ptr_reg == stepper_pkg::R_IN) ? {4'h0, pin_reg.gpio} :
    (ptr_reg == stepper_pkg::R_FLAG) ? {4'h0, int_flag_reg} :
    (ptr_reg == stepper_pkg::R_WDCTL) ? wd_view : reg_sel;

  // Bus slave next state; start and stop override any bit in flight
  always_comb begin
    st_next = st_reg;
    nxt_next = nxt_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    ack_next = ack_reg;
    oe_next = oe_reg;
    gc_next = gc_reg;
    if (start_det) begin
      st_next = stepper_pkg::ST_ADDR;
      cnt_next = 4'h0;
      ack_next = 1'b0;
      oe_next = 1'b0;
      gc_next = 1'b0;
    end else if (stop_det) begin
      st_next = stepper_pkg::ST_IDLE;
      ack_next = 1'b0;
      oe_next = 1'b0;
      gc_next = 1'b0;
    end else if (scl_rise & ~ack_reg & (st_reg != stepper_pkg::ST_SKIP)
                 & (st_reg != stepper_pkg::ST_IDLE)) begin
      sh_next = {sh_reg[6:0], pin_reg.sda};
      cnt_next = cnt_reg + 4'h1;
    end else if (mst_nack) begin
      st_next = stepper_pkg::ST_SKIP;
    end else if (decide) begin
      ack_next = 1'b1;
      case (st_reg)
        stepper_pkg::ST_ADDR: begin
          oe_next = own_hit | gc_wr;
          nxt_next = own_hit ? (sh_reg[0] ? stepper_pkg::ST_RDATA
                                          : stepper_pkg::ST_PTR)
                   : gc_wr ? stepper_pkg::ST_GCODE : stepper_pkg::ST_SKIP;
        end
        stepper_pkg::ST_PTR: begin
          oe_next = 1'b1;
          ptr_next = sh_reg[3:0];
          nxt_next = stepper_pkg::ST_WDATA;
        end
        stepper_pkg::ST_WDATA: begin
          oe_next = 1'b1;
          ptr_next = ptr_reg + 4'h1;
          nxt_next = stepper_pkg::ST_WDATA;
        end
        stepper_pkg::ST_GCODE: begin
          oe_next = code_ok;
          gc_next = code_ok;
          nxt_next = code_ok ? stepper_pkg::ST_GMORE : stepper_pkg::ST_SKIP;
        end
        default: begin
          oe_next = 1'b0;
          gc_next = 1'b0;
          nxt_next = stepper_pkg::ST_SKIP;
        end
      endcase
    end else if (scl_fall & ~ack_reg & (st_reg == stepper_pkg::ST_RDATA)) begin
      if (cnt_reg == 4'h8) begin
        ack_next = 1'b1; // Release for the master's answer
        oe_next = 1'b0;
      end else begin
        tx_next = {tx_reg[6:0], 1'b1};
        oe_next = ~tx_reg[6];
      end
    end else if (ack_end) begin
      ack_next = 1'b0;
      cnt_next = 4'h0;
      st_next = nxt_reg;
      tx_next = rd_data;
      oe_next = load_tx & ~rd_data[7];
    end
  end

  // Bus slave state; the software reset fires on the stop only
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= stepper_pkg::ST_IDLE;
      nxt_reg <= stepper_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 4'h0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      gc_reg <= 1'b0;
      bus_reset_call_reg <= 1'b0;
    end else if (clr) begin
      st_reg <= stepper_pkg::ST_IDLE;
      nxt_reg <= stepper_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 4'h0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      gc_reg <= 1'b0;
      bus_reset_call_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      nxt_reg <= nxt_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      ack_reg <= ack_next;
      oe_reg <= oe_next;
      gc_reg <= gc_next;
      bus_reset_call_reg <= stop_det & gc_reg;
    end
  end

  // Register file; read-only entries are shadowed by live state
  genvar gi;
  generate
    for (gi = 0; gi < stepper_pkg::NREG; gi++) begin : g_reg
      wire logic hit = wr_en & (wr_idx == 4'(gi));
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          regs_reg[gi] <= stepper_pkg::REG_RESET;
        end else if (clr) begin
          regs_reg[gi] <= stepper_pkg::REG_RESET;
        end else if (hit) begin
          regs_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Pin interrupts: input direction, unmasked, selected edge
  wire logic [3:0] dir_out = regs_reg[stepper_pkg::R_DIR][3:0];
  wire logic [3:0] mask_en = regs_reg[stepper_pkg::R_MASK][3:0];
  wire logic [7:0] edge_sel = regs_reg[stepper_pkg::R_EDGE];
  wire logic [3:0] g_rise = pin_reg.gpio & ~pin_prev_reg.gpio;
  wire logic [3:0] g_fall = ~pin_reg.gpio & pin_prev_reg.gpio;
  wire logic [3:0] pin_evt = ~dir_out & mask_en &
    ((g_rise & edge_sel[3:0]) | (g_fall & edge_sel[7:4]));
  wire logic flag_rd = load_tx & (ptr_reg == stepper_pkg::R_FLAG);
  // Set wins over the clear-on-read so no edge is lost
  wire logic [3:0] flag_next = pin_evt |
    (flag_rd ? 4'h0 : int_flag_reg);

  // Watchdog counts units since the last register write
  wire logic wd_en = regs_reg[stepper_pkg::R_WDCTL][stepper_pkg::WD_EN_BIT];
  wire logic [7:0] wd_time = regs_reg[stepper_pkg::R_WDTIME];
  wire logic wd_kick = wr_en | ~wd_en;
  wire logic unit_done = wd_pre_reg == 14'(WD_UNIT_CYCLES - 1);
  wire logic wd_expire = wd_en & unit_done &
    ({1'b0, wd_cnt_reg} + 9'h001 >= {1'b0, wd_time});
  wire logic wd_clr = wr_en & (wr_idx == stepper_pkg::R_WDCTL) &
                      ~wr_data[stepper_pkg::WD_FLAG_BIT];
  wire logic int_off = regs_reg[stepper_pkg::R_MODE][stepper_pkg::MODE_INT_OFF];
  wire logic pending = (|int_flag_reg) | wd_flag_reg;

  // Interrupt flags, watchdog and pin drive
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_flag_reg <= 4'h0;
      wd_flag_reg <= 1'b0;
      int_oe_reg <= 1'b0;
      wd_pre_reg <= 14'h0000;
      wd_cnt_reg <= 8'h00;
    end else if (clr) begin
      int_flag_reg <= 4'h0;
      wd_flag_reg <= 1'b0;
      int_oe_reg <= 1'b0;
      wd_pre_reg <= 14'h0000;
      wd_cnt_reg <= 8'h00;
    end else begin
      int_flag_reg <= flag_next;
      wd_flag_reg <= wd_expire | (wd_flag_reg & ~wd_clr);
      int_oe_reg <= pending & ~int_off;
      wd_pre_reg <= (wd_kick | unit_done) ? 14'h0000 : wd_pre_reg + 14'h0001;
      wd_cnt_reg <= (wd_kick | wd_expire) ? 8'h00
                  : unit_done ? wd_cnt_reg + 8'h01 : wd_cnt_reg;
    end
  end

  // Step period timer restarts on each start, so the first advance
  // comes one full period after the resumed pattern appears
  wire logic run = regs_reg[stepper_pkg::R_MOTOR][stepper_pkg::RUN_BIT];
  wire logic ccw = regs_reg[stepper_pkg::R_MOTOR][stepper_pkg::CCW_BIT];
  wire logic step_hold = ~run | ~run_q_reg;
  wire logic su_done = step_pre_reg == 7'(stepper_pkg::STEP_UNIT_CYC - 1);
  wire logic step_tick = ~step_hold & su_done &
    ({1'b0, step_cnt_reg} + 9'h001 >=
     {1'b0, regs_reg[stepper_pkg::R_STEP]});
  assign cmd = {run, ccw, regs_reg[stepper_pkg::R_MODE][1:0]};

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_q_reg <= 1'b0;
      step_pre_reg <= 7'h00;
      step_cnt_reg <= 8'h00;
    end else if (clr) begin
      run_q_reg <= 1'b0;
      step_pre_reg <= 7'h00;
      step_cnt_reg <= 8'h00;
    end else begin
      run_q_reg <= run;
      step_pre_reg <= (step_hold | su_done) ? 7'h00 : step_pre_reg + 7'h01;
      step_cnt_reg <= (step_hold | step_tick) ? 8'h00
                    : su_done ? step_cnt_reg + 8'h01 : step_cnt_reg;
    end
  end

  phase_sequencer u_seq (
    .clk(CLK),
    .arst_n(ARST_N),
    .clr(clr),
    .cmd(cmd),
    .step_tick(step_tick),
    .coil(coil)
  );

  // Open-drain lines only ever pull low; enables carry the state
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_reg;
  assign INT_N_OUT = 1'b0;
  assign INT_N_OE = int_oe_reg;
  assign GPIO_OUT = regs_reg[stepper_pkg::R_OUT][3:0];
  assign GPIO_OE = dir_out;
  assign COIL_DRIVE_FIRST = coil[0];
  assign COIL_DRIVE_SECOND = coil[1];
  assign COIL_DRIVE_THIRD = coil[2];
  assign COIL_DRIVE_FOURTH = coil[3];

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_pin_reset:
  assert property (!pin_reg.rst_n |=> st_reg == stepper_pkg::ST_IDLE &&
                   !SDA_OE && !INT_N_OE && GPIO_OE == 4'h0)
    else $error("reset pin did not hold defaults");
  a_start_seen:
  assert property ((start_det && !clr) |=>
                   st_reg == stepper_pkg::ST_ADDR && cnt_reg == 4'h0)
    else $error("start not taken");
  a_gcall_ack:
  assert property ((decide && st_reg == stepper_pkg::ST_ADDR &&
                    sh_reg[7:1] == 7'h00 && !clr) |=> SDA_OE == !$past(sh_reg[0]))
    else $error("general call answer wrong for direction");
  a_code_ack:
  assert property ((decide && st_reg == stepper_pkg::ST_GCODE && !clr)
                   |=> SDA_OE == ($past(sh_reg) == 8'h06) && ack_reg)
    else $error("reset code answer wrong");
  a_extra_nack:
  assert property (st_reg == stepper_pkg::ST_GMORE |-> !SDA_OE)
    else $error("byte after reset code acknowledged");
  a_bus_reset_call_stop:
  assert property ((stop_det && gc_reg && !clr) |=> bus_reset_call_reg ##1
                   (st_reg == stepper_pkg::ST_IDLE && cmd == 4'h0 && !gc_reg))
    else $error("software reset not performed on stop");
  a_sr_cancel:
  assert property ((start_det && !clr) |=> !gc_reg ##1 !bus_reset_call_reg)
    else $error("repeated start did not cancel reset");
  a_wd_flag:
  assert property ((wd_expire && !clr) |=> wd_flag_reg && wd_cnt_reg == 8'h00)
    else $error("watchdog expiry lost");
  a_pin_flag:
  assert property ((pin_evt != 4'h0 && !clr) |=>
                   (int_flag_reg & $past(pin_evt)) == $past(pin_evt))
    else $error("pin interrupt flag not set");
  a_int_assert:
  assert property ((pin_evt != 4'h0 && !int_off && !clr) ##1
                   (!int_off && !clr) |=> INT_N_OE)
    else $error("interrupt line not pulled low");
  a_int_gate:
  assert property (int_off [*2] |-> !INT_N_OE)
    else $error("disabled interrupt line driven");
  a_ack_hold:
  assert property ((ack_reg && SDA_OE && st_reg != stepper_pkg::ST_RDATA &&
                    !scl_fall && !start_det && !stop_det && !clr) |=> SDA_OE)
    else $error("acknowledge dropped before clock fall");
  a_rd_release:
  assert property ((mst_nack && !start_det && !stop_det && !clr) |=>
                   st_reg == stepper_pkg::ST_SKIP && !SDA_OE [*2])
    else $error("line not released after master refusal");

  c_soft_reset: cover property (bus_reset_call_reg);
  c_read_done: cover property (mst_nack);
  c_pin_int: cover property (pin_evt != 4'h0 && !int_off);
  c_wd_fire: cover property (wd_expire);
endmodule // stepper_ctrl

// [stepper_pkg.sv]
// Shared constants and types for the stepper phase and bus controller
package stepper_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WD_UNIT_US = 1000;
  localparam int WD_UNIT_CYC = WD_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int STEP_UNIT_US = 10;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * 1000 / CLK_PERIOD_NS;
  // Bus slave address and reserved codes
  localparam logic [6:0] DEV_ADDR = 7'h20;
  localparam logic [7:0] GCALL_WR = 8'h00;
  localparam logic [7:0] RESET_CODE = 8'h06;
  // Register indexes
  localparam int NREG = 11;
  localparam logic [3:0] R_MODE = 4'h0;
  localparam logic [3:0] R_WDCTL = 4'h1;
  localparam logic [3:0] R_WDTIME = 4'h2;
  localparam logic [3:0] R_DIR = 4'h3;
  localparam logic [3:0] R_OUT = 4'h4;
  localparam logic [3:0] R_IN = 4'h5;
  localparam logic [3:0] R_MASK = 4'h6;
  localparam logic [3:0] R_EDGE = 4'h7;
  localparam logic [3:0] R_FLAG = 4'h8;
  localparam logic [3:0] R_STEP = 4'h9;
  localparam logic [3:0] R_MOTOR = 4'ha;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int MODE_INT_OFF = 5;
  localparam int WD_EN_BIT = 0;
  localparam int WD_FLAG_BIT = 3;
  localparam int RUN_BIT = 7;
  localparam int CCW_BIT = 0;
  // Half-step table, entry i in nibble i: D,DC,C,CB,B,BA,A,AD
  localparam logic [31:0] PHASE_TABLE = 32'h98c46231;
  localparam logic [2:0] CW_HOME = 3'h0;
  localparam logic [2:0] CCW_HOME = 3'h6;
  // Pins idle high at reset
  localparam logic [6:0] SYNC_INIT = 7'h7f;
  typedef enum logic [1:0] {
    DRV_WAVE = 2'b00,
    DRV_TWO = 2'b01,
    DRV_HALF = 2'b10,
    DRV_HALF_ALT = 2'b11
  } drive_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_GCODE = 3'b101,
    ST_GMORE = 3'b110,
    ST_SKIP = 3'b111
  } bus_st_t;
  typedef struct packed {
    logic rst_n;
    logic scl;
    logic sda;
    logic [3:0] gpio;
  } pins_t;
  typedef struct packed {
    logic run;
    logic ccw;
    drive_t drive;
  } motor_cmd_t;
endpackage

// [phase_sequencer.sv]
// Coil phase sequence generator for wave, two-phase and half-step drive
`timescale 1ns/1ps
module phase_sequencer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire stepper_pkg::motor_cmd_t cmd,
  input wire logic step_tick,
  output logic [3:0] coil
);
  logic [2:0] pos_reg;
  logic [2:0] pos_next;
  logic started_reg;
  logic run_q_reg;
  logic [3:0] coil_reg;
  logic [3:0] coil_next;

  // Position walks the half-step table; full modes use every other entry
  wire logic start = cmd.run & ~run_q_reg;
  wire logic wave = cmd.drive == stepper_pkg::DRV_WAVE;
  wire logic two = cmd.drive == stepper_pkg::DRV_TWO;
  wire logic [2:0] stride = (wave | two) ? 3'h2 : 3'h1;
  wire logic [2:0] home = cmd.ccw ? stepper_pkg::CCW_HOME
                                  : stepper_pkg::CW_HOME;
  wire logic [2:0] walk = cmd.ccw ? pos_reg - stride
                                  : pos_reg + stride;
  wire logic advance = cmd.run & run_q_reg & step_tick;
  assign pos_next = (start & ~started_reg) ? home
                  : advance ? walk : pos_reg;
  wire logic [2:0] idx = wave ? {pos_next[2:1], 1'b0}
                       : two ? {pos_next[2:1], 1'b1}
                       : pos_next;
  // Bit 0 is winding D on the first output, bit 3 winding A
  wire logic [3:0] pattern =
    stepper_pkg::PHASE_TABLE[{idx, 2'b00} +: 4];
  // Coils are released while stopped; position is kept for the restart
  assign coil_next = cmd.run ? pattern : 4'h0;
  assign coil = coil_reg;

  // Sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_reg <= 3'h0;
      started_reg <= 1'b0;
      run_q_reg <= 1'b0;
      coil_reg <= 4'h0;
    end else if (clr) begin
      pos_reg <= 3'h0;
      started_reg <= 1'b0;
      run_q_reg <= 1'b0;
      coil_reg <= 4'h0;
    end else begin
      pos_reg <= pos_next;
      started_reg <= started_reg | start;
      run_q_reg <= cmd.run;
      coil_reg <= coil_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_wave_single:
  assert property ((cmd.run && wave && !clr) |=> $onehot(coil_reg))
    else $error("wave drive not exactly one winding");
  a_two_pair:
  assert property ((cmd.run && two && !clr) |=> $countones(coil_reg) == 2)
    else $error("two-phase drive not two windings");
  a_half_walk:
  assert property ((advance && !wave && !two && !cmd.ccw && !clr)
                   |=> pos_reg == $past(pos_reg) + 3'h1)
    else $error("half-step did not move one entry forward");
  a_first_ref:
  assert property ((start && !started_reg && !clr)
                   |=> (cmd.ccw ? coil_reg[3] : coil_reg[0]))
    else $error("first start not on reference coil");
  a_resume_pos:
  assert property ((start && started_reg && !clr)
                   |=> pos_reg == $past(pos_reg))
    else $error("restart did not resume stop position");
  c_half_wrap: cover property (advance && !cmd.ccw && pos_reg == 3'h7);
endmodule // phase_sequencer

// [bus_master_model.sv]
// Bus master model: bit-level two-wire master with byte tasks
`timescale 1ns/1ps
module bus_master_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // Clock stands high while the bus is idle
  initial scl = 1'b1;
  initial sda_drv = 1'b1;
  // Data moves only while clock low, far from its edges
  task automatic bit_io(input logic b, input int lo, output logic r);
    #lo sda_drv = b;
    #200 scl = 1'b1;
    #400 r = sda;
    scl = 1'b0;
  endtask
  // Start when lvl is 0, stop when lvl is 1, both with clock high
  task automatic cond(input logic lvl);
    #600 sda_drv = ~lvl;
    #200 scl = 1'b1;
    #400 sda_drv = lvl;
    #400 scl = lvl;
  endtask
  // Long low ahead of the first bit lets the slave drop its answer
  // The slave moves its line five cycles after a fall, so any bit it drives
  // gets a long low phase; a short one would look like a start or stop
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], (i == 7) ? 600 : 200, r);
    end
    bit_io(1'b1, 600, ack);
  endtask
  // Refusing the last byte makes the slave let go of the line
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 600, d[i]);
    end
    bit_io(nack, 600, r);
  endtask
endmodule // bus_master_model

// [tb_top.sv]
// Testbench: coil sequences, interrupts and both resets
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic RESET_N = 1'b1;
  logic [3:0] GPIO_IN = 4'h0;
  logic scl, sda_drv, sda_oe, int_oe, ack, sda_out, int_out;
  logic [3:0] gpio_oe, gpio_out, coil, prev;
  logic [7:0] rd;
  logic [3:0] seen[$];
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  // Pull-ups on both open-drain lines
  wire sda = sda_drv & (~sda_oe | sda_out);
  wire int_n = ~int_oe | int_out;
  bus_master_model master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  stepper_ctrl #(.WD_UNIT_CYCLES(20)) uut (.CLK(CLK), .ARST_N(ARST_N),
    .RESET_N(RESET_N), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .INT_N_OUT(int_out), .INT_N_OE(int_oe),
    .GPIO_IN(GPIO_IN), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
    .COIL_DRIVE_FIRST(coil[0]),
    .COIL_DRIVE_SECOND(coil[1]), .COIL_DRIVE_THIRD(coil[2]),
    .COIL_DRIVE_FOURTH(coil[3]));
  always #50 CLK = ~CLK;
  // Timeout, and a log of every newly energized pattern
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    prev <= coil;
    if (coil !== prev && coil !== 4'h0) seen.push_back(coil);
    if (cycles == 80000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] p, d);
    master.cond(1'b0);
    master.put({stepper_pkg::DEV_ADDR, 1'b0}, ack);
    chk("addr ack", ack, 1'b0);
    master.put(p, ack);
    master.put(d, ack);
    chk("data ack", ack, 1'b0);
    master.cond(1'b1);
  endtask
  task automatic rdr(input logic [7:0] p);
    master.cond(1'b0);
    master.put({stepper_pkg::DEV_ADDR, 1'b0}, ack);
    master.put(p, ack);
    master.cond(1'b0);
    master.put({stepper_pkg::DEV_ADDR, 1'b1}, ack);
    master.get(1'b1, rd);
    master.cond(1'b1);
  endtask
  // Half-step order D, DC, C, CB, B, BA, A, AD on outputs 1..4
  localparam logic [31:0] HALF = 32'h98c46231;
  // Mode switch may remap the resumed pattern, so from=1 skips that pair
  task automatic run(input logic [7:0] mode, motor, input int st, from);
    int k;
    logic [3:0] last;
    last = (seen.size() > 0) ? seen[$] : 4'h1;
    wr(8'h00, mode);
    seen.delete();
    wr(8'h0a, motor);
    repeat (700) @(posedge CLK);
    wr(8'h0a, 8'h00);
    if (from == 0) chk("resume", seen[0], last);
    for (int i = from; i + 1 < seen.size(); i++) begin
      k = 0;
      while (HALF[4*k +: 4] != seen[i] && k < 7) k++;
      chk("step", seen[i+1], HALF[4*((k+st+8)%8) +: 4]);
    end
    $display("coil run done");
  endtask
  task automatic irq_test();
    wr(8'h06, 8'h01);
    wr(8'h07, 8'h01);
    @(posedge CLK) #1 GPIO_IN[0] = 1'b1;
    repeat (10) @(posedge CLK);
    chk("int pin", int_n, 1'b0);
    rdr(8'h08);
    chk("pin flag", rd, 8'h01);
    chk("int clear", int_n, 1'b1);
    wr(8'h00, 8'h20);
    wr(8'h07, 8'h10);
    @(posedge CLK) #1 GPIO_IN[0] = 1'b0;
    repeat (10) @(posedge CLK);
    chk("int off", int_n, 1'b1);
    rdr(8'h08);
    chk("fall flag", rd, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    repeat (60) @(posedge CLK);
    chk("wd int", int_n, 1'b0);
    rdr(8'h01);
    chk("wd flag", rd, 8'h09);
    $display("interrupt test done");
  endtask
  // General call: address, n code bytes, optional repeated start
  task automatic gc(input logic [7:0] a, input int n, input logic [2:0] e,
    input logic [7:0] code, input bit rs);
    master.cond(1'b0);
    master.put(a, ack);
    chk("gc addr", ack, e[0]);
    for (int i = 1; i <= n; i++) begin
      master.put(code, ack);
      chk("gc code", ack, e[i]);
    end
    if (rs) master.cond(1'b0);
    master.cond(1'b1);
  endtask
  task automatic resets();
    wr(8'h03, 8'h0f);
    wr(8'h04, 8'h0a);
    chk("pin out", {gpio_oe, gpio_out}, 8'hfa);
    // Output pins toggle under a selected, unmasked edge: no flag
    @(posedge CLK) #1 GPIO_IN = 4'hb;
    repeat (10) @(posedge CLK);
    #1 GPIO_IN = 4'ha;
    rdr(8'h08);
    chk("out pin no flag", rd, 8'h00);
    rdr(8'h05);
    chk("pin in", rd, 8'h0a);
    gc(8'h01, 0, 3'b001, 8'h06, 0);
    gc(8'h00, 1, 3'b010, 8'h05, 0);
    gc(8'h00, 2, 3'b100, 8'h06, 0);
    gc(8'h00, 1, 3'b000, 8'h06, 1);
    chk("no reset", gpio_oe, 4'hf);
    gc(8'h00, 1, 3'b000, 8'h06, 0);
    repeat (5) @(posedge CLK);
    chk("soft reset", {gpio_oe, 3'b000, int_n}, 8'h01);
    chk("soft reset out", gpio_out, 4'h0);
    repeat (10000) @(posedge CLK);
    wr(8'h03, 8'h0f);
    @(posedge CLK) #1 RESET_N = 1'b0;
    repeat (10) @(posedge CLK);
    chk("pin reset", gpio_oe, 4'h0);
    #1 RESET_N = 1'b1;
    repeat (10000) @(posedge CLK);
    rdr(8'h03);
    chk("after pin reset", rd, 8'h00);
    $display("reset test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    #1 ARST_N = 1'b1;
    repeat (10) @(posedge CLK);
    run(8'h00, 8'h80, 2, 0);
    run(8'h00, 8'h81, -2, 0);
    run(8'h02, 8'h80, 1, 0);
    run(8'h03, 8'h81, -1, 0); // Drive code 11 selects half-step too
    run(8'h01, 8'h80, 2, 1);
    irq_test();
    resets();
    tally_and_finish();
  end
endmodule // tb_top
